// ### hdl/gifd_regs.svh
`ifndef GIFD_REGS_SVH
`define GIFD_REGS_SVH
// input function codes
`define GIFD_FN_FAULT_DUMP 4'h2
`define GIFD_FN_CURRENT_OUTPUT_PWR 4'h3
`define GIFD_FN_VOLTAGE_OUTPUT_PWR 4'h4
`define GIFD_FN_PROTECT 4'h5
`define GIFD_FN_CLEAR 4'h7
`define GIFD_FN_LOAD 4'h8
`define GIFD_FN_FUNCGEN 4'h9
`define GIFD_FN_MARGIN 4'ha
`define GIFD_FN_RESET 4'hb
`define GIFD_FN_NVM_GATE 4'hc
`define GIFD_FN_REG_GATE 4'hd
// reset values of gate states
`define GIFD_NVM_ALLOW_RST 1'b1
`define GIFD_REG_ALLOW_RST 1'b1
// synchroniser depth for the pin
`define GIFD_SYNC_STAGES 3
`endif

// ### hdl/gifd_pkg.sv
`default_nettype none
package gifd_pkg;
	// channel-targeted command strobes
	typedef struct packed {
		logic [3:0] current_output_pdn;
		logic [3:0] current_output_pup;
		logic [3:0] voltage_output_pdn;
		logic [3:0] voltage_output_pup;
		logic [3:0] load;
		logic [3:0] fg_stop;
		logic [3:0] fg_start;
		logic [3:0] margin_lo;
		logic [3:0] margin_hi;
	} gifd_chan_cmd_t;
	// device-wide command strobes
	typedef struct packed {
		logic fault_dump;
		logic protect;
		logic clear_cmd;
		logic dev_reset;
	} gifd_glob_cmd_t;
	// pin-controlled gate states
	typedef struct packed {
		logic nvm_allow;
		logic reg_allow;
	} gifd_gate_t;
	typedef enum logic [1:0] {
		GIFD_BOOT = 2'b00,
		GIFD_RUN = 2'b01
	} gifd_state_t;
endpackage : gifd_pkg
`default_nettype wire

// ### hdl/gifd_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "gifd_regs.svh"
module gifd_pin_sync
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// raw pin
	input wire logic pin_in,
	// filtered level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic [2:0] sync_q;
	logic [2:0] sync_d;
	logic level_q;
	logic level_d;
	// shift chain; change counts when stages two and three agree
	always_comb
	begin
		sync_d = {sync_q[1:0], pin_in};
		level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_q <= 3'h7;
			level_q <= 1'b1;
		end
		else
		begin
			sync_q <= sync_d;
			level_q <= level_d;
		end
	end
	assign level = level_q;
	assign rise = level_d & ~level_q;
	assign fall = ~level_d & level_q;
endmodule : gifd_pin_sync
`default_nettype wire

// ### hdl/gifd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "gifd_regs.svh"
// What this block does
// - volatile reset mode lost after reset
// - code 0010 falling edge dumps faults
// - code 0011 edges power current outputs
// - code 0100 edges power voltage outputs
// - code 0101 falling edge triggers protect
// - code 0111 falling edge triggers clear
// - code 1000 falling edge loads synced channels
// - code 1001 edges stop/start waveform generation
// - code 1010 edges select margin low/high
// - code 1011 low pulse resets; needs nvm
// - code 1100 edges allow/block nvm programming
// - code 1101 edges allow/block register writes
// - other codes cause no command
// - pin is input only when enabled
// - mapped function masks matching software bit
// - after power-up sample level once, execute
module gifd_decoder
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin
	input wire logic gpio_pin,
	// configuration
	input wire logic input_enable_bit,
	input wire logic [3:0] input_function_code,
	input wire logic [3:0] input_channel_select,
	input wire logic [3:0] sync_update_enable,
	input wire logic [3:0] voltage_output_powerdown_option,
	input wire logic cfg_from_nvm,
	// command strobes
	output gifd_pkg::gifd_chan_cmd_t chan_cmd,
	output gifd_pkg::gifd_glob_cmd_t glob_cmd,
	output logic [3:0] voltage_output_pdn_option,
	// gates and software masks
	output gifd_pkg::gifd_gate_t gate,
	output logic sw_bit_disable,
	output logic [3:0] sw_fn_code
);
	import gifd_pkg::*;

	// ==========================================
	// pin synchroniser
	logic level;
	logic rise;
	logic fall;
	gifd_pin_sync u_sync
	(
		.clk(clk),
		.rst(rst),
		.pin_in(gpio_pin),
		.level(level),
		.rise(rise),
		.fall(fall)
	);

	// ==========================================
	// boot sequencing
	gifd_state_t state_q;
	gifd_state_t state_d;
	logic [1:0] boot_cnt_q;
	logic [1:0] boot_cnt_d;
	logic boot_fire;
	// wait until synchroniser is filled, then act on level once
	always_comb
	begin
		state_d = state_q;
		boot_cnt_d = boot_cnt_q;
		boot_fire = 1'b0;
		unique case (state_q)
			GIFD_BOOT:
			begin
				boot_cnt_d = boot_cnt_q + 2'h1;
				if (boot_cnt_q == 2'h3)
				begin
					boot_fire = 1'b1;
					state_d = GIFD_RUN;
				end
			end
			GIFD_RUN:
			begin
				boot_cnt_d = boot_cnt_q;
			end
			default:
			begin
				state_d = GIFD_BOOT;
			end
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= GIFD_BOOT;
			boot_cnt_q <= 2'h0;
		end
		else
		begin
			state_q <= state_d;
			boot_cnt_q <= boot_cnt_d;
		end
	end

	// ==========================================
	// event qualification
	logic active;
	logic ev_fall;
	logic ev_rise;
	logic low_pulse_q;
	logic low_pulse_d;
	logic boot_lvl;
	// effective events: edges in run, or boot level treated as its edge
	always_comb
	begin
		active = input_enable_bit;
		// level the chain settles to now; the registered level still holds the reset value
		boot_lvl = (level & ~fall) | rise;
		ev_fall = active & ((state_q == GIFD_RUN & fall) | (boot_fire & ~boot_lvl));
		ev_rise = active & ((state_q == GIFD_RUN & rise) | (boot_fire & boot_lvl));
		// low pulse completes on rise after a seen fall
		low_pulse_d = low_pulse_q;
		if (ev_fall)
			low_pulse_d = 1'b1;
		else if (rise | ~active)
			low_pulse_d = 1'b0;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			low_pulse_q <= 1'b0;
		else
			low_pulse_q <= low_pulse_d;
	end

	// ==========================================
	// command decode
	gifd_chan_cmd_t cc_d;
	gifd_chan_cmd_t cc_q;
	gifd_glob_cmd_t gc_d;
	gifd_glob_cmd_t gc_q;
	gifd_gate_t gate_d;
	gifd_gate_t gate_q;
	logic [3:0] pdo_d;
	logic [3:0] pdo_q;
	logic [3:0] sel;
	always_comb
	begin
		cc_d = '0;
		gc_d = '0;
		gate_d = gate_q;
		pdo_d = pdo_q;
		sel = input_channel_select;
		unique case (input_function_code)
			`GIFD_FN_FAULT_DUMP: gc_d.fault_dump = ev_fall;
			`GIFD_FN_CURRENT_OUTPUT_PWR:
			begin
				cc_d.current_output_pdn = ev_fall ? sel : 4'h0;
				cc_d.current_output_pup = ev_rise ? sel : 4'h0;
			end
			`GIFD_FN_VOLTAGE_OUTPUT_PWR:
			begin
				cc_d.voltage_output_pdn = ev_fall ? sel : 4'h0;
				cc_d.voltage_output_pup = ev_rise ? sel : 4'h0;
				if (ev_fall)
					pdo_d = voltage_output_powerdown_option;
			end
			`GIFD_FN_PROTECT: gc_d.protect = ev_fall;
			`GIFD_FN_CLEAR: gc_d.clear_cmd = ev_fall;
			`GIFD_FN_LOAD: cc_d.load = ev_fall ? (sel & sync_update_enable) : 4'h0;
			`GIFD_FN_FUNCGEN:
			begin
				cc_d.fg_stop = ev_fall ? sel : 4'h0;
				cc_d.fg_start = ev_rise ? sel : 4'h0;
			end
			`GIFD_FN_MARGIN:
			begin
				cc_d.margin_lo = ev_fall ? sel : 4'h0;
				cc_d.margin_hi = ev_rise ? sel : 4'h0;
			end
			// only a stored config survives the reset it causes
			`GIFD_FN_RESET: gc_d.dev_reset = low_pulse_q & rise & active & cfg_from_nvm;
			`GIFD_FN_NVM_GATE:
			begin
				if (ev_fall)
					gate_d.nvm_allow = 1'b1;
				else if (ev_rise)
					gate_d.nvm_allow = 1'b0;
			end
			`GIFD_FN_REG_GATE:
			begin
				if (ev_fall)
					gate_d.reg_allow = 1'b1;
				else if (ev_rise)
					gate_d.reg_allow = 1'b0;
			end
			default: cc_d = '0;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cc_q <= '0;
			gc_q <= '0;
			gate_q <= {`GIFD_NVM_ALLOW_RST, `GIFD_REG_ALLOW_RST};
			pdo_q <= 4'h0;
		end
		else
		begin
			cc_q <= cc_d;
			gc_q <= gc_d;
			gate_q <= gate_d;
			pdo_q <= pdo_d;
		end
	end

	// ==========================================
	// outputs
	assign chan_cmd = cc_q;
	assign glob_cmd = gc_q;
	assign gate = gate_q;
	assign voltage_output_pdn_option = pdo_q;
	// software command path of the mapped function is masked
	assign sw_bit_disable = input_enable_bit;
	assign sw_fn_code = input_function_code;
endmodule : gifd_decoder
`default_nettype wire

// ### bench/gifd_pin_drv.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// far-side pin driver, pull-up holds the pin high when idle
module gifd_pin_drv
(
	// control
	input wire logic drive,
	input wire logic level,
	// pin
	output logic pin
);
	// never leave the pin floating
	assign pin = drive ? level : 1'b1;
endmodule : gifd_pin_drv
`default_nettype wire

// ### bench/gifd_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// decoder port checker
module gifd_chk
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic input_enable_bit,
	input wire logic [3:0] input_function_code,
	input wire logic [3:0] input_channel_select,
	input wire logic [3:0] sync_update_enable,
	input wire logic [3:0] voltage_output_powerdown_option,
	input wire logic cfg_from_nvm,
	// outputs
	input wire gifd_pkg::gifd_chan_cmd_t chan_cmd,
	input wire gifd_pkg::gifd_glob_cmd_t glob_cmd,
	input wire logic [3:0] voltage_output_pdn_option,
	input wire gifd_pkg::gifd_gate_t gate,
	input wire logic sw_bit_disable,
	input wire logic [3:0] sw_fn_code
);
	import gifd_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// properties
	off_quiet_a: assert property ((!input_enable_bit) [*3] |-> {chan_cmd, glob_cmd} == '0)
		else $error("command while disabled");
	nop_quiet_a: assert property ((!(input_function_code inside {[4'h2:4'h5], [4'h7:4'hd]})) [*3]
		|-> {chan_cmd, glob_cmd} == '0)
		else $error("command on unlisted code");
	one_strobe_a: assert property (|chan_cmd |=> !(|chan_cmd))
		else $error("strobe longer than a cycle");
	sw_mask_a: assert property (sw_bit_disable == input_enable_bit && sw_fn_code == input_function_code)
		else $error("software mask wrong");
	load_mask_a: assert property ((chan_cmd.load & ~$past(input_channel_select & sync_update_enable)) == 4'h0)
		else $error("load outside mask");
	reset_nvm_a: assert property (glob_cmd.dev_reset |-> $past(cfg_from_nvm))
		else $error("reset without nvm config");
	gate_code_a: assert property ($changed(gate) |-> $past(input_function_code) inside {4'hc, 4'hd})
		else $error("gate moved on other code");
	pdn_opt_a: assert property (|chan_cmd.voltage_output_pdn |-> voltage_output_pdn_option == $past(voltage_output_powerdown_option))
		else $error("pulldown option not captured");
	// main scenarios
	cover property (|chan_cmd.load);
	cover property (glob_cmd.dev_reset);
	cover property ($fell(gate.reg_allow));
endmodule : gifd_chk
bind gifd_decoder gifd_chk i_chk
(
	.clk(clk),
	.rst(rst),
	.input_enable_bit(input_enable_bit),
	.input_function_code(input_function_code),
	.input_channel_select(input_channel_select),
	.sync_update_enable(sync_update_enable),
	.voltage_output_powerdown_option(voltage_output_powerdown_option),
	.cfg_from_nvm(cfg_from_nvm),
	.chan_cmd(chan_cmd),
	.glob_cmd(glob_cmd),
	.voltage_output_pdn_option(voltage_output_pdn_option),
	.gate(gate),
	.sw_bit_disable(sw_bit_disable),
	.sw_fn_code(sw_fn_code)
);
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// decoder testbench
module tb;
	import gifd_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic drv = 0;
	logic lvl = 1;
	logic en = 0;
	logic nvm = 0;
	logic [3:0] code = 4'h0;
	logic [3:0] sel = 4'h5;
	logic [3:0] opt = 4'h9;
	logic [3:0] eo = 4'h0;
	logic [3:0] vo;
	logic sd;
	logic [3:0] sf;
	wire logic pin;
	gifd_chan_cmd_t cc;
	gifd_glob_cmd_t gc;
	gifd_gate_t gt;
	gifd_gate_t eg = 2'b11;
	logic [39:0] acc;
	int miscompares = 0;
	int checks = 0;
	// 100 MHz clock
	initial
	begin
		forever #5 clk = ~clk;
	end
	gifd_pin_drv i_gifd_pin_drv (.drive(drv), .level(lvl), .pin(pin));
	gifd_decoder i_gifd_decoder (.clk(clk), .rst(rst), .gpio_pin(pin), .input_enable_bit(en),
		.input_function_code(code), .input_channel_select(sel), .sync_update_enable(4'h3),
		.voltage_output_powerdown_option(opt), .cfg_from_nvm(nvm), .chan_cmd(cc),
		.glob_cmd(gc), .voltage_output_pdn_option(vo), .gate(gt), .sw_bit_disable(sd), .sw_fn_code(sf));
	// compare and count
	task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// set pin level, gather strobes for 10 cycles
	task automatic hit(input logic v);
		lvl = v;
		acc = '0;
		repeat (10)
		begin
			@(posedge clk);
			#1;
			acc = acc | {cc, gc};
		end
	endtask : hit
	// expected strobes for select s, load mask s and 3
	function automatic logic [39:0] ex(input logic [3:0] c, input logic f, input logic n,
		input logic [3:0] s);
		gifd_chan_cmd_t e;
		gifd_glob_cmd_t g;
		e = '0;
		g = '0;
		case (c)
			4'h2: g.fault_dump = f;
			4'h3: {e.current_output_pdn, e.current_output_pup} = f ? {s, 4'h0} : {4'h0, s};
			4'h4: {e.voltage_output_pdn, e.voltage_output_pup} = f ? {s, 4'h0} : {4'h0, s};
			4'h5: g.protect = f;
			4'h7: g.clear_cmd = f;
			4'h8: e.load = f ? (s & 4'h3) : 4'h0;
			4'h9: {e.fg_stop, e.fg_start} = f ? {s, 4'h0} : {4'h0, s};
			4'ha: {e.margin_lo, e.margin_hi} = f ? {s, 4'h0} : {4'h0, s};
			4'hb: g.dev_reset = !f && n;
			default: e = '0;
		endcase
		return {e, g};
	endfunction : ex
	// verdict
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	// passes: enabled with nvm, disabled, enabled without nvm
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		rst = 0;
		drv = 1;
		hit(1'b1);
		for (int p = 0; p < 3; p++)
		begin
			en = p != 1;
			nvm = p == 0;
			sel = (p == 0) ? 4'h5 : 4'ha;
			opt = (p == 0) ? 4'h9 : 4'h6;
			for (int c = 0; c < 16; c++)
			begin
				code = c[3:0];
				for (int f = 0; f < 2; f++)
				begin
					hit(f[0]);
					chk("cmd", acc, en ? ex(code, f == 0, nvm, sel) : 40'h0);
					if (en && code == 4'h4 && f == 0)
						eo = opt;
					chk("pdn opt", {36'h0, vo}, {36'h0, eo});
					chk("sw mask", {35'h0, sd, sf}, {35'h0, en, code});
					if (en && code == 4'hc)
						eg.nvm_allow = f == 0;
					if (en && code == 4'hd)
						eg.reg_allow = f == 0;
					chk("gate", {38'h0, gt}, {38'h0, eg});
				end
			end
			$display("test pass %0d done", p);
		end
		code = 4'h3;
		lvl = 0;
		rst = 1;
		repeat (10) @(posedge clk);
		#1;
		rst = 0;
		hit(1'b0);
		chk("boot", acc, ex(4'h3, 1'b1, 1'b0, sel));
		chk("boot opt", {36'h0, vo}, 40'h0);
		$display("test boot done");
		test_done();
	end
	// watchdog
	initial
	begin
		#200000;
		miscompares++;
		test_done();
	end
endmodule : tb
`default_nettype wire
